/* common/ssu_map.svh */
// register offsets, field positions, reset values and timing counts
`ifndef SSU_MAP_SVH
`define SSU_MAP_SVH
`define SSU_OFS_CTRL        4'h0
`define SSU_OFS_STAT        4'h1
`define SSU_OFS_DATU        4'h2
`define SSU_OFS_DATL        4'h3
`define SSU_OFS_STOP        4'h4
`define SSU_CTRL_RST        8'h00
`define SSU_STAT_SOL        6
`define SSU_STAT_OVR        5
`define SSU_STAT_TMF        1
`define SSU_STAT_GO         0
`define SSU_STOP_RST        8'hff
`define SSU_STOP_BIT        7
`define SSU_TAIL_CLKS       6'd3
`endif

/* common/ssu_pkg.sv */
// types of the serial shift unit
package ssu_pkg;
  typedef enum logic [1:0] {MODE_8, MODE_16, MODE_CONT, MODE_RSVD} ssu_mode_t;
  typedef struct packed {
    ssu_mode_t  mode;
    logic       tail_mark_enable;
    logic       tail_latch;
    logic       clock_source_sel;
    logic [2:0] clock_div_sel;
  } ssu_ctrl_t;
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_TAIL} ssu_state_t;
endpackage

/* src/ssu_prescaler.sv */
// prescaler producing the internal serial clock level
`timescale 1ns/100ps
`include "ssu_map.svh"
module ssu_prescaler
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // control
  input  wire logic       run,
  input  wire logic [2:0] sel,
  input  wire logic       sub_tick,
  // serial clock level
  output logic            sclk_ff
);
  logic [9:0] cnt_ff;
  logic [9:0] half;
  logic       hit;

  // half period minus one for each divider setting, in system clocks (in sub ticks for setting 7)
  assign half = (sel == 3'h0) ? 10'h1ff : (sel == 3'h1) ? 10'h07f :
                (sel == 3'h2) ? 10'h01f : (sel == 3'h3) ? 10'h00f :
                (sel == 3'h4) ? 10'h007 : (sel == 3'h5) ? 10'h003 :
                (sel == 3'h6) ? 10'h001 : 10'h001;
  assign hit  = (cnt_ff >= half);

  // counter, idle level high
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff  <= 10'h000;
      sclk_ff <= 1'b1;
    end
    else if (ce)
    begin
      if (!run)
      begin
        cnt_ff  <= 10'h000;
        sclk_ff <= 1'b1;
      end
      else if (sel != 3'h7 || sub_tick)
      begin
        cnt_ff  <= hit ? 10'h000 : cnt_ff + 10'h001;
        sclk_ff <= hit ? ~sclk_ff : sclk_ff;
      end
    end
  end
endmodule

/* src/ssu_top.sv */
// synchronous serial shift unit with avalon register slave
`timescale 1ns/100ps
`include "ssu_map.svh"
module ssu_top
(
  // system
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  input  wire logic        CE,
  input  wire logic        SUB_TICK,
  // avalon-mm slave
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // serial pins
  input  wire logic        SCLK_IN,
  output logic             SCLK_OUT,
  output logic             SCLK_OE,
  input  wire logic        SDIN,
  output logic             SDOUT,
  // events
  output logic             XFER_DONE
);
  ssu_pkg::ssu_ctrl_t  ctrl_ff;
  ssu_pkg::ssu_state_t state_ff;
  logic [7:0] upper_ff;
  logic [7:0] lower_ff;
  logic       standby_ff;
  logic       so_ff;
  logic       ovr_ff;
  logic       ovr_seen_ff;
  logic       go_ff;
  logic [4:0] bitcnt_ff;
  logic [5:0] tailcnt_ff;
  logic [2:0] ext_sync_ff;
  logic       ack_ff;
  logic [31:0] rdata_ff;
  logic       sclk_out_ff;
  logic       sclk_oe_ff;
  logic       done_ff;
  logic       int_sclk;
  logic       sclk_prev_ff;

  // bus decode
  wire req      = (AVS_READ | AVS_WRITE) & ~ack_ff;
  wire wr       = AVS_WRITE & ~ack_ff & CE;
  wire wr_ctrl  = wr & (AVS_ADDRESS == `SSU_OFS_CTRL);
  wire wr_stat  = wr & (AVS_ADDRESS == `SSU_OFS_STAT);
  wire wr_datu  = wr & (AVS_ADDRESS == `SSU_OFS_DATU);
  wire wr_datl  = wr & (AVS_ADDRESS == `SSU_OFS_DATL);
  wire wr_stop  = wr & (AVS_ADDRESS == `SSU_OFS_STOP);
  wire rd_stat  = AVS_READ & ~ack_ff & CE & (AVS_ADDRESS == `SSU_OFS_STAT);
  wire [7:0] wb = AVS_WRITEDATA[7:0];

  // mode decode
  wire ext_clk   = ctrl_ff.clock_source_sel;
  wire is16      = (ctrl_ff.mode == ssu_pkg::MODE_16);
  wire is_cont   = (ctrl_ff.mode == ssu_pkg::MODE_CONT);
  wire busy      = (state_ff != ssu_pkg::ST_IDLE);
  wire mod_rst   = ~standby_ff;
  wire [4:0] nbits = is16 ? 5'd16 : 5'd8;

  // serial clock selection and edges (external input after 3 flops)
  wire ext_lvl   = ext_sync_ff[2];
  wire ext_agree = (ext_sync_ff[1] == ext_sync_ff[2]);
  wire sclk_cur  = ext_clk ? (ext_agree ? ext_lvl : sclk_prev_ff) : int_sclk;
  wire sclk_rise = sclk_cur & ~sclk_prev_ff;
  wire sclk_fall = ~sclk_cur & sclk_prev_ff;
  wire shifting  = (state_ff == ssu_pkg::ST_SHIFT);
  wire last_bit  = shifting & sclk_rise & (bitcnt_ff == nbits - 5'd1);
  wire tail_cnt_done = (tailcnt_ff == `SSU_TAIL_CLKS) & sclk_rise;
  wire tail_end  = (state_ff == ssu_pkg::ST_TAIL) & (tail_cnt_done);
  wire pres_run  = ~ext_clk & (shifting | is_cont |
                   (state_ff == ssu_pkg::ST_TAIL));

  // shift chain: new bit at top, upper feeds lower in 16-bit mode
  wire [7:0] nxt_lower = {is16 ? upper_ff[0] : SDIN, lower_ff[7:1]};
  wire [7:0] nxt_upper = {SDIN, upper_ff[7:1]};

  // status read image: bit 7 reads 1, bits 4..2 read 0
  wire [7:0] stat_img = {1'b1, so_ff, ovr_ff, 3'b000,
                         (state_ff == ssu_pkg::ST_TAIL) & ctrl_ff.tail_mark_enable,
                         go_ff};
  wire [7:0] rd_mux = (AVS_ADDRESS == `SSU_OFS_CTRL) ? ctrl_ff :
                      (AVS_ADDRESS == `SSU_OFS_STAT) ? stat_img :
                      (AVS_ADDRESS == `SSU_OFS_DATU) ? upper_ff :
                      (AVS_ADDRESS == `SSU_OFS_DATL) ? lower_ff :
                      (AVS_ADDRESS == `SSU_OFS_STOP) ? {standby_ff, 7'h7f} : 8'h00;

  ssu_prescaler u_pres
  (
    .clk      (CLK_SYS),
    .rst      (SYS_RST),
    .ce       (CE),
    .run      (pres_run & standby_ff),
    .sel      (ctrl_ff.clock_div_sel),
    .sub_tick (SUB_TICK),
    .sclk_ff  (int_sclk)
  );

  // bus answer: one wait cycle, then ack
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end
    else if (CE)
    begin
      ack_ff   <= req;
      rdata_ff <= {24'h000000, rd_mux};
    end
  end

  // external clock synchroniser and edge reference
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ext_sync_ff  <= 3'b111;
      sclk_prev_ff <= 1'b1;
    end
    else if (CE)
    begin
      ext_sync_ff  <= {ext_sync_ff[1:0], SCLK_IN};
      sclk_prev_ff <= sclk_cur;
    end
  end

  // standby bit and control register
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      standby_ff <= 1'b1;
      ctrl_ff    <= `SSU_CTRL_RST;
    end
    else if (CE)
    begin
      if (wr_stop)
        standby_ff <= wb[`SSU_STOP_BIT];
      if (mod_rst)
        ctrl_ff <= `SSU_CTRL_RST;
      else if (wr_ctrl)
        ctrl_ff <= wb;
    end
  end

  // transfer state machine, go flag and completion pulse
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      state_ff   <= ssu_pkg::ST_IDLE;
      go_ff      <= 1'b0;
      bitcnt_ff  <= 5'd0;
      tailcnt_ff <= 6'd0;
      done_ff    <= 1'b0;
    end
    else if (CE)
    begin
      done_ff <= 1'b0;
      if (mod_rst || (wr_ctrl && !busy))
      begin
        state_ff <= ssu_pkg::ST_IDLE;
        go_ff    <= 1'b0;
      end
      else
      begin
        unique case (state_ff)
          ssu_pkg::ST_IDLE:
          begin
            if (wr_stat && wb[`SSU_STAT_GO] && !is_cont)
            begin
              state_ff  <= ssu_pkg::ST_SHIFT;
              go_ff     <= 1'b1;
              bitcnt_ff <= 5'd0;
            end
          end
          ssu_pkg::ST_SHIFT:
          begin
            if (shifting && sclk_rise)
              bitcnt_ff <= bitcnt_ff + 5'd1;
            if (last_bit)
            begin
              go_ff      <= 1'b0;
              done_ff    <= 1'b1;
              tailcnt_ff <= 6'd0;
              state_ff   <= ctrl_ff.tail_mark_enable ? ssu_pkg::ST_TAIL
                                                     : ssu_pkg::ST_IDLE;
            end
          end
          ssu_pkg::ST_TAIL:
          begin
            if (sclk_rise)
              tailcnt_ff <= tailcnt_ff + 6'd1;
            if (tail_end)
              state_ff <= ssu_pkg::ST_IDLE;
          end
          default:
            state_ff <= ssu_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // shift bytes: no reset value, cleared by standby
  always_ff @(posedge CLK_SYS)
  begin
    if (CE)
    begin
      if (mod_rst)
      begin
        upper_ff <= 8'h00;
        lower_ff <= 8'h00;
      end
      else if (shifting && sclk_rise)
      begin
        lower_ff <= nxt_lower;
        if (is16)
          upper_ff <= nxt_upper;
      end
      else
      begin
        if (wr_datu)
          upper_ff <= wb;
        if (wr_datl)
          lower_ff <= wb;
      end
    end
  end

  // serial output level and overrun flag
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      so_ff       <= 1'b0;
      ovr_ff      <= 1'b0;
      ovr_seen_ff <= 1'b0;
    end
    else if (CE)
    begin
      if (mod_rst)
      begin
        so_ff       <= 1'b0;
        ovr_ff      <= 1'b0;
        ovr_seen_ff <= 1'b0;
      end
      else
      begin
        if (shifting && (sclk_fall || bitcnt_ff == 5'd0 && !sclk_prev_ff))
          so_ff <= lower_ff[0];
        else if (shifting && bitcnt_ff == 5'd0 && sclk_fall)
          so_ff <= lower_ff[0];
        else if (wr_stat && !busy && !ctrl_ff.tail_mark_enable)
          so_ff <= wb[`SSU_STAT_SOL];
        if (rd_stat && ovr_ff)
          ovr_seen_ff <= 1'b1;
        // set wins over clear
        if (ext_clk && !busy && !go_ff && sclk_rise && !is_cont)
          ovr_ff <= 1'b1;
        else if (wr_stat && !wb[`SSU_STAT_OVR] && ovr_seen_ff)
        begin
          ovr_ff      <= 1'b0;
          ovr_seen_ff <= 1'b0;
        end
      end
    end
  end

  // pin outputs from flops
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      sclk_out_ff <= 1'b1;
      sclk_oe_ff  <= 1'b1;
    end
    else if (CE)
    begin
      sclk_out_ff <= int_sclk;
      sclk_oe_ff  <= ~ext_clk;
    end
  end

  assign AVS_READDATA    = rdata_ff;
  assign AVS_WAITREQUEST = ~ack_ff;
  assign SCLK_OUT        = sclk_out_ff;
  assign SCLK_OE         = sclk_oe_ff;
  assign SDOUT           = so_ff;
  assign XFER_DONE       = done_ff;

  // assertions
  property p_go_done;
    @(posedge CLK_SYS) disable iff (SYS_RST) $fell(go_ff) && CE |-> XFER_DONE;
  endproperty
  a_go_done: assert property (p_go_done) else $error("go cleared without done pulse");
  property p_done_pulse;
    @(posedge CLK_SYS) disable iff (SYS_RST) XFER_DONE |=> !XFER_DONE;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  property p_rsvd;
    @(posedge CLK_SYS) disable iff (SYS_RST) stat_img[4:2] == 3'b000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved status bits not zero");
  property p_oe;
    @(posedge CLK_SYS) disable iff (SYS_RST) CE |=> SCLK_OE == ~$past(ext_clk);
  endproperty
  a_oe: assert property (p_oe) else $error("clock pin direction wrong");
  property p_start;
    @(posedge CLK_SYS) disable iff (SYS_RST)
      CE && !busy && !mod_rst && !wr_ctrl && !is_cont && wr_stat && wb[0] |=> go_ff;
  endproperty
  a_start: assert property (p_start) else $error("go write did not start");
  property p_tail;
    @(posedge CLK_SYS) disable iff (SYS_RST) stat_img[1] |-> !go_ff;
  endproperty
  a_tail: assert property (p_tail) else $error("tail flag during data");
  property p_standby;
    @(posedge CLK_SYS) disable iff (SYS_RST) CE && mod_rst |=> !go_ff && !ovr_ff;
  endproperty
  a_standby: assert property (p_standby) else $error("standby did not reset");
  property p_ovr_hold;
    @(posedge CLK_SYS) disable iff (SYS_RST)
      ovr_ff && !wr_stat && !mod_rst |=> ovr_ff;
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("overrun cleared without write");
endmodule

/* testbench/ssu_peer.sv */
// serial peripheral model on the far side of the shift unit
`timescale 1ns/100ps
module ssu_peer
(
  // system clock for edge detection
  input  wire logic clk,
  // serial pins
  input  wire logic sclk_out,
  input  wire logic sclk_oe,
  input  wire logic sdout,
  output logic      sclk_in,
  output logic      sdin
);
  logic [15:0] tx_ff = 16'h0;
  logic [15:0] rx_ff = 16'h0;
  logic [4:0]  len_ff = 5'h0;
  logic [4:0]  rises_ff = 5'h0;
  logic [4:0]  falls_ff = 5'h0;
  logic        prev_ff = 1'b1;
  wire  logic  sclk_eff = sclk_oe ? sclk_out : sclk_in;

  // idle clock line high, data line not yet meaningful
  initial
  begin
    sclk_in = 1'b1;
    sdin = 1'b1;
  end

  // arm one frame; data line shows the wrong level until the first fall
  task load(input logic [15:0] d, input logic [4:0] n);
    tx_ff = d;
    len_ff = n;
    rises_ff = 5'h0;
    falls_ff = 5'h0;
    sdin = ~d[0];
  endtask

  // external clock pulses, low then high
  task ext(input int n);
    repeat (n)
    begin
      repeat (6) @(posedge clk);
      sclk_in <= 1'b0;
      repeat (6) @(posedge clk);
      sclk_in <= 1'b1;
    end
  endtask

  // capture on rise, present next bit on fall, scramble after the frame
  always @(posedge clk)
  begin
    prev_ff <= sclk_eff;
    if (sclk_eff && !prev_ff && rises_ff != 5'h1f)
      rises_ff <= rises_ff + 5'h1;
    if (sclk_eff && !prev_ff && rises_ff < len_ff)
      rx_ff <= {sdout, rx_ff[15:1]};
    if (!sclk_eff && prev_ff && falls_ff < len_ff)
    begin
      falls_ff <= falls_ff + 5'h1;
      sdin <= tx_ff[0];
      tx_ff <= tx_ff >> 1;
    end
    else if (rises_ff >= len_ff && falls_ff >= len_ff)
      sdin <= ~sdin;
  end
endmodule

/* testbench/ssu_top_bench.sv */
// self-checking bench of the serial shift unit over its register bus
`timescale 1ns/100ps
module ssu_top_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  sub_cnt = 3'h0;
  logic        sub_tick = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic        rd_en = 1'b0;
  logic        wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  wire  logic [31:0] rdat;
  wire  logic  wait_req;
  wire  logic  sclk_out;
  wire  logic  sclk_oe;
  wire  logic  sclk_in;
  wire  logic  sdin;
  wire  logic  sdout;
  wire  logic  done;
  int          miscompares = 0;
  int          compares = 0;
  logic [7:0]  v;
  logic [15:0] p;
  logic        s;
  logic [15:0] ratio [7] = '{16'h0400, 16'h0100, 16'h0040, 16'h0020,
                             16'h0010, 16'h0008, 16'h0004};

  // clock and subclock tick
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    sub_cnt <= sub_cnt + 3'h1;
    sub_tick <= (sub_cnt == 3'h0);
  end

  ssu_top i_dut (.CLK_SYS(clk), .SYS_RST(rst), .CE(1'b1), .SUB_TICK(sub_tick),
    .AVS_ADDRESS(adr), .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdat),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_req), .SCLK_IN(sclk_in),
    .SCLK_OUT(sclk_out), .SCLK_OE(sclk_oe), .SDIN(sdin), .SDOUT(sdout),
    .XFER_DONE(done));
  ssu_peer i_peer (.clk(clk), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .sdout(sdout), .sclk_in(sclk_in), .sdin(sdin));

  // verdict and end of run
  task conclude;
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // compare and report
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  // one avalon access, held until waitrequest is seen low
  task bus(input logic [3:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge clk);
    adr <= a;
    rd_en <= ~w;
    wr_en <= w;
    wdat <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wait_req !== 1'b0 && n < 100);
    v = rdat[7:0];
    if (wait_req !== 1'b0)
      chk(16'(wait_req), 16'h0);
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask

  task rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    chk(16'(v & m), 16'(e));
  endtask

  // wait for the completion pulse, then see it drop
  task wdone;
    int n;
    n = 0;
    while (done !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    chk(16'(done), 16'h1);
    @(posedge clk);
    chk(16'(done), 16'h0);
  endtask

  // set up and start one frame
  task xfer(input logic [7:0] c, u, l, input logic [15:0] pd, input logic [4:0] n);
    wr(4'h0, c);
    wr(4'h2, u);
    wr(4'h3, l);
    i_peer.load(pd, n);
    wr(4'h1, 8'h01);
  endtask

  // serial clock period in system cycles, second rise to third
  task per(output logic [15:0] c);
    logic pv;
    int   k;
    int   n;
    c = 16'h0;
    pv = sclk_out;
    k = 0;
    n = 0;
    while (k < 3 && n < 5000)
    begin
      @(posedge clk);
      n++;
      if (k == 2)
        c++;
      if (sclk_out && !pv)
        k++;
      pv = sclk_out;
    end
  endtask

  // hang guard
  initial
  begin
    repeat (30000) @(posedge clk);
    miscompares++;
    conclude;
  end

  // test sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rc(4'hf, 8'hff, 8'h00);
    rc(4'h0, 8'hff, 8'h00);
    rc(4'h4, 8'hff, 8'hff);
    rc(4'h1, 8'h7f, 8'h00);
    chk(16'(sclk_oe), 16'h1);
    wr(4'h1, 8'h5c);
    rc(4'h1, 8'h7f, 8'h40);
    chk(16'(sdout), 16'h1);
    wr(4'h1, 8'h00);
    repeat (3) @(posedge clk);
    chk(16'(sdout), 16'h0);
    wr(4'h0, 8'h06);
    wr(4'h1, 8'h00);
    repeat (60) @(posedge clk);
    chk(16'(i_peer.rises_ff), 16'h0);
    // 8-bit frame, internal clock
    xfer(8'h06, 8'h00, 8'ha5, 16'h003c, 5'd8);
    wdone;
    chk(16'(i_peer.rx_ff[15:8]), 16'h00a5);
    chk(16'(i_peer.rises_ff), 16'd8);
    rc(4'h3, 8'hff, 8'h3c);
    rc(4'h1, 8'h41, 8'h40);
    // 16-bit frame
    xfer(8'h46, 8'h96, 8'h5a, 16'hc3e1, 5'd16);
    wdone;
    chk(i_peer.rx_ff, 16'h965a);
    chk(16'(i_peer.rises_ff), 16'd16);
    rc(4'h3, 8'hff, 8'he1);
    rc(4'h2, 8'hff, 8'hc3);
    // external clock, then surplus pulses
    xfer(8'h0e, 8'h00, 8'h81, 16'h0096, 5'd8);
    chk(16'(sclk_oe), 16'h0);
    fork
      i_peer.ext(8);
      wdone;
    join
    chk(16'(i_peer.rx_ff[15:8]), 16'h0081);
    rc(4'h3, 8'hff, 8'h96);
    i_peer.ext(2);
    rc(4'h1, 8'h20, 8'h20);
    wr(4'h1, 8'h20);
    rc(4'h1, 8'h20, 8'h20);
    wr(4'h1, 8'h00);
    rc(4'h1, 8'h20, 8'h00);
    // continuous clock at prescaler ratios 0 to 6
    for (int i = 0; i < 7; i++)
    begin
      wr(4'h0, {5'b10000, 3'(i)});
      per(p);
      chk(p, ratio[i]);
    end
    // tail-mark bus mode
    xfer(8'h26, 8'h00, 8'h0f, 16'h0000, 5'd8);
    wdone;
    rc(4'h1, 8'h03, 8'h02);
    repeat (60) @(posedge clk);
    rc(4'h1, 8'h02, 8'h00);
    s = sdout;
    wr(4'h1, {1'b0, ~s, 6'h00});
    repeat (3) @(posedge clk);
    chk(16'(sdout), 16'(s));
    // module standby clears the unit
    wr(4'h0, 8'h06);
    wr(4'h3, 8'h77);
    wr(4'h4, 8'h7f);
    rc(4'h4, 8'hff, 8'h7f);
    rc(4'h0, 8'hff, 8'h00);
    rc(4'h3, 8'hff, 8'h00);
    rc(4'h2, 8'hff, 8'h00);
    rc(4'h1, 8'h23, 8'h00);
    wr(4'h4, 8'hff);
    rc(4'h4, 8'hff, 8'hff);
    conclude;
  end
endmodule
